// ==== rtl/dbut_top.sv ====
// Purpose: Dual byte universal transceiver, card side to backplane side
// Assumes: All pins synchronous to clk_sys; capture clock is sampled
// Notes: Two-way pins split into in, out and enable; log of clocked
//        card-to-backplane captures drains over a stream port
//
// The plain strobed port and the register addresses were chosen for this implementation.

`timescale 1ns/100ps

module dbut_top #(
    parameter int LANE_W = dbut_pkg::LANE_W,
    parameter int LOG_DEPTH = dbut_pkg::LOG_DEPTH
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    input wire logic xfer_clk,
    input wire logic [1:0] card_to_backplane_latch_open,
    input wire logic [1:0] backplane_to_card_latch_open,
    input wire logic [1:0] card_to_backplane_drive_en_n,
    input wire logic [1:0] backplane_to_card_drive_en_n,
    input wire logic bus_disable,
    input wire logic [2*LANE_W-1:0] card_in,
    output logic [2*LANE_W-1:0] card_out,
    output logic [2*LANE_W-1:0] card_oe,
    input wire logic [2*LANE_W-1:0] bp_in,
    output logic [2*LANE_W-1:0] bp_out,
    output logic [2*LANE_W-1:0] bp_oe,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic log_valid,
    input wire logic log_ready,
    output logic [2*LANE_W-1:0] log_data
);

    localparam int WW = 2 * LANE_W;
    localparam int LW = $clog2(LOG_DEPTH+1);

    // ********************************************************
    // Capture clock edge
    // ********************************************************
    logic xfer_clk_d_r;                     // Capture clock, last cycle
    wire clk_rise = xfer_clk & ~xfer_clk_d_r;

    // Previous capture clock level; follows the pin in reset, so no false edge
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            xfer_clk_d_r <= xfer_clk;
        else if (ce)
            xfer_clk_d_r <= xfer_clk;
    end

    // ********************************************************
    // Data paths
    // ********************************************************
    wire [WW-1:0] ab_q;                     // Card to backplane store
    wire [WW-1:0] ba_q;                     // Backplane to card store

    genvar ln;
    generate
        for (ln = 0; ln < 2; ln++)
        begin : g_lane
            dbut_store #(.W(LANE_W)) u_ab (
                .clk_sys(clk_sys),
                .srst(srst),
                .ce(ce),
                .latch_open(card_to_backplane_latch_open[ln]),
                .clk_rise(clk_rise),
                .din(card_in[ln*LANE_W +: LANE_W]),
                .dout(ab_q[ln*LANE_W +: LANE_W])
            );
            dbut_store #(.W(LANE_W)) u_ba (
                .clk_sys(clk_sys),
                .srst(srst),
                .ce(ce),
                .latch_open(backplane_to_card_latch_open[ln]),
                .clk_rise(clk_rise),
                .din(bp_in[ln*LANE_W +: LANE_W]),
                .dout(ba_q[ln*LANE_W +: LANE_W])
            );
        end
    endgenerate

    // Data pins come straight from the stores
    assign bp_out = ab_q;
    assign card_out = ba_q;

    // ********************************************************
    // Drive enables
    // ********************************************************
    logic sw_dis_r;                         // Software driver disable
    wire all_off = bus_disable | sw_dis_r;
    wire [WW-1:0] bp_oe_nxt;
    wire [WW-1:0] card_oe_nxt;

    assign bp_oe_nxt = {{LANE_W{~card_to_backplane_drive_en_n[1]}},
                        {LANE_W{~card_to_backplane_drive_en_n[0]}}} & {WW{~all_off}};
    assign card_oe_nxt = {{LANE_W{~backplane_to_card_drive_en_n[1]}},
                          {LANE_W{~backplane_to_card_drive_en_n[0]}}} & {WW{~all_off}};

    // Registered enables, off in reset
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            bp_oe <= '0;
            card_oe <= '0;
        end
        else if (ce)
        begin
            bp_oe <= bp_oe_nxt;
            card_oe <= card_oe_nxt;
        end
    end

    // ********************************************************
    // Capture log
    // ********************************************************
    wire log_in_ready;
    wire [LW-1:0] log_level;
    // Clocked captures in either lane of the card path
    wire log_push = clk_rise & ~(&card_to_backplane_latch_open);

    dbut_fifo #(.WIDTH(WW), .DEPTH(LOG_DEPTH)) u_log (
        .clk_sys(clk_sys),
        .srst(srst),
        .ce(ce),
        .in_valid(log_push),
        .in_ready(log_in_ready),
        .in_data(card_in),
        .out_valid(log_valid),
        .out_ready(log_ready),
        .out_data(log_data),
        .level(log_level)
    );

    // ********************************************************
    // Register port
    // ********************************************************
    logic ovf_r;                            // Log overflow, sticky
    wire hit_ctrl = (reg_addr == dbut_pkg::ADDR_CTRL);
    wire hit_held = (reg_addr == dbut_pkg::ADDR_HELD);
    wire hit_log = (reg_addr == dbut_pkg::ADDR_LOG);
    wire ovf_set = ce & log_push & ~log_in_ready;
    wire ovf_clr = reg_wr & hit_ctrl & reg_wdata[dbut_pkg::CTRL_OVF_CLR_BIT];
    wire [31:0] ctrl_view;
    wire [31:0] rd_mux;

    assign ctrl_view = (32'(ovf_r) << dbut_pkg::CTRL_OVF_BIT)
                     | (32'(sw_dis_r) << dbut_pkg::CTRL_SW_DIS_BIT);
    // Unmapped addresses read zero
    assign rd_mux = hit_ctrl ? ctrl_view
                  : hit_held ? 32'({ba_q, ab_q})
                  : hit_log ? 32'(log_level)
                  : dbut_pkg::RDATA_RST;

    // Control register and overflow flag; set beats clear
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            sw_dis_r <= 1'b0;
            ovf_r <= 1'b0;
        end
        else if (ce)
        begin
            if (reg_wr && hit_ctrl)
                sw_dis_r <= reg_wdata[dbut_pkg::CTRL_SW_DIS_BIT];
            if (ovf_set)
                ovf_r <= 1'b1;
            else if (ovf_clr)
                ovf_r <= 1'b0;
        end
    end

    // Read data for one cycle only
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            reg_rdata <= dbut_pkg::RDATA_RST;
        else if (ce)
            reg_rdata <= reg_rd ? rd_mux : dbut_pkg::RDATA_RST;
    end

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    // Lane 0 card latch open for a cycle, then closed
    sequence s_ab0_close;
        ce && card_to_backplane_latch_open[0]
        ##1 ce && !card_to_backplane_latch_open[0] && !clk_rise;
    endsequence

    // Two more closed cycles without capture edge
    sequence s_ab0_quiet;
        (ce && !card_to_backplane_latch_open[0] && !clk_rise) [*2];
    endsequence

    AST_AB_TRANSP: assert property (
        ce && card_to_backplane_latch_open[0]
        |=> bp_out[LANE_W-1:0] == $past(card_in[LANE_W-1:0]))
        else $error("card path not transparent while open");

    AST_AB_LATCH: assert property (
        s_ab0_close ##0 s_ab0_quiet
        |-> bp_out[LANE_W-1:0] == $past(card_in[LANE_W-1:0], 2))
        else $error("card path lost value held at latch close");

    AST_AB_CLOCKED: assert property (
        ce && !card_to_backplane_latch_open[1] && clk_rise
        |=> bp_out[WW-1:LANE_W] == $past(card_in[WW-1:LANE_W]))
        else $error("card path missed clock rise capture");

    AST_AB_HOLD: assert property (
        !card_to_backplane_latch_open[0] && !clk_rise
        |=> $stable(bp_out[LANE_W-1:0]))
        else $error("closed card path changed without edge");

    AST_BA_TRANSP: assert property (
        ce && backplane_to_card_latch_open[1]
        |=> card_out[WW-1:LANE_W] == $past(bp_in[WW-1:LANE_W]))
        else $error("backplane path not transparent while open");

    AST_COMMON_CLK: assert property (
        ce && clk_rise && !card_to_backplane_latch_open[0]
        && !backplane_to_card_latch_open[1]
        |=> bp_out[LANE_W-1:0] == $past(card_in[LANE_W-1:0])
        && card_out[WW-1:LANE_W] == $past(bp_in[WW-1:LANE_W]))
        else $error("shared clock did not capture both directions");

    AST_BP_OE: assert property (
        ce && !all_off && !card_to_backplane_drive_en_n[0]
        |=> bp_oe[LANE_W-1:0] == '1)
        else $error("backplane byte one not driven");

    AST_CARD_OE: assert property (
        ce && backplane_to_card_drive_en_n[1]
        |=> card_oe[WW-1:LANE_W] == '0)
        else $error("card byte two driven while disabled");

    AST_GLOBAL_DIS: assert property (
        ce && bus_disable ##1 ce && bus_disable
        |=> bp_oe == '0 && card_oe == '0)
        else $error("outputs driven under global disable");

    AST_LANE_SEP: assert property (
        ce && $stable(card_to_backplane_drive_en_n[0]) && $stable(all_off)
        && $past(ce) && !$past(srst) |=> $stable(bp_oe[LANE_W-1:0]))
        else $error("byte one enable moved with other lane");

    // Lane 1 backplane latch open for a cycle, then closed
    sequence s_ba1_close;
        ce && backplane_to_card_latch_open[1]
        ##1 ce && !backplane_to_card_latch_open[1] && !clk_rise;
    endsequence

    // Two more closed cycles on that path without capture edge
    sequence s_ba1_quiet;
        (ce && !backplane_to_card_latch_open[1] && !clk_rise) [*2];
    endsequence

    // Mirror path keeps the value it had at latch close
    AST_BA_LATCH: assert property (
        s_ba1_close ##0 s_ba1_quiet
        |-> card_out[WW-1:LANE_W] == $past(bp_in[WW-1:LANE_W], 2))
        else $error("backplane path lost value held at latch close");

    // Mirror path loads on a capture edge while closed
    AST_BA_CLOCKED: assert property (
        ce && !backplane_to_card_latch_open[0] && clk_rise
        |=> card_out[LANE_W-1:0] == $past(bp_in[LANE_W-1:0]))
        else $error("backplane path missed clock rise capture");

    // Closed mirror path without edge keeps its output
    AST_BA_HOLD: assert property (
        !backplane_to_card_latch_open[1] && !clk_rise
        |=> $stable(card_out[WW-1:LANE_W]))
        else $error("closed backplane path changed without edge");

    // Byte two card path follows its input while open
    AST_AB_TRANSP2: assert property (
        ce && card_to_backplane_latch_open[1]
        |=> bp_out[WW-1:LANE_W] == $past(card_in[WW-1:LANE_W]))
        else $error("byte two card path not transparent while open");

    // Byte one mirror path follows its input while open
    AST_BA_TRANSP0: assert property (
        ce && backplane_to_card_latch_open[0]
        |=> card_out[LANE_W-1:0] == $past(bp_in[LANE_W-1:0]))
        else $error("byte one backplane path not transparent while open");

    // Frozen clock enable keeps both data paths still
    AST_FREEZE: assert property (
        !ce |=> $stable(bp_out) && $stable(card_out))
        else $error("data path moved while clock enable low");

    // Global disable clears every enable one cycle later
    AST_DIS_NOW: assert property (
        ce && bus_disable |=> bp_oe == '0 && card_oe == '0)
        else $error("enable left on after global disable");

    // Byte two backplane drive off while its enable is high
    AST_BP_OE_OFF: assert property (
        ce && card_to_backplane_drive_en_n[1]
        |=> bp_oe[WW-1:LANE_W] == '0)
        else $error("backplane byte two driven while disabled");

    // Card byte one drives when enabled and not disabled
    AST_CARD_OE_ON: assert property (
        ce && !all_off && !backplane_to_card_drive_en_n[0]
        |=> card_oe[LANE_W-1:0] == '1)
        else $error("card byte one not driven");

    // Card byte two enable ignores the other lane
    AST_LANE_SEP2: assert property (
        ce && $stable(backplane_to_card_drive_en_n[1]) && $stable(all_off)
        && $past(ce) && !$past(srst) |=> $stable(card_oe[WW-1:LANE_W]))
        else $error("card byte two enable moved with other lane");

    // A logged capture stands until the drain takes it
    AST_LOG_STAND: assert property (
        ce && log_valid && !log_ready
        |=> log_valid && $stable(log_data))
        else $error("logged capture dropped before drain took it");

endmodule

// ==== rtl/dbut_pkg.sv ====
// Purpose: Shared constants for the dual byte universal transceiver
// Assumes: One system clock, synchronous active-high reset
// Notes: Offsets are byte addresses on the plain register port

package dbut_pkg;

    // ********************************************************
    // Data path shape
    // ********************************************************
    localparam int LANE_W = 8;              // Bits per lane
    localparam int LANES = 2;               // Lanes per device
    localparam int WORD_W = 16;             // Both lanes side by side
    localparam int LOG_DEPTH = 32;          // Capture log depth

    // ********************************************************
    // Register port
    // ********************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] ADDR_CTRL = 8'h00;    // Control and flags
    localparam logic [7:0] ADDR_HELD = 8'h04;    // Stored path values
    localparam logic [7:0] ADDR_LOG = 8'h08;     // Log fill level

    // Control register fields
    localparam int CTRL_SW_DIS_BIT = 0;     // Software disable of all drivers
    localparam int CTRL_OVF_CLR_BIT = 1;    // Write one to clear overflow
    localparam int CTRL_OVF_BIT = 8;        // Log overflow flag, read only

    // Values after reset
    localparam logic [LANE_W-1:0] STORE_RST = 8'h00;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

endpackage

// ==== rtl/dbut_store.sv ====
// Purpose: One lane, one direction storage element
// Assumes: Capture clock edge is found by the caller
// Notes: Open latch follows data; closed latch loads on clock edges

`timescale 1ns/100ps

module dbut_store #(
    parameter int W = 8
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    input wire logic latch_open,
    input wire logic clk_rise,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    // ********************************************************
    // Storage
    // ********************************************************
    // Load when open or on a capture edge, else hold
    wire load_now = latch_open | clk_rise;

    // Single register, frozen by clock enable
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            dout <= W'(dbut_pkg::STORE_RST);
        else if (ce && load_now)
            dout <= din;
    end

endmodule

// ==== rtl/dbut_fifo.sv ====
// Purpose: Capture log buffer with valid and ready on both sides
// Assumes: Single clock, synchronous reset
// Notes: Output stage is a register so the drain side sees flop outputs

`timescale 1ns/100ps

module dbut_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] level
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    // ********************************************************
    // Storage and pointers
    // ********************************************************
    logic [WIDTH-1:0] mem [DEPTH];          // Entry array
    logic [AW-1:0] wr_ptr_r;                // Next write slot
    logic [AW-1:0] rd_ptr_r;                // Next read slot
    logic [CW-1:0] cnt_r;                   // Entries in array

    // Handshake terms
    wire push = ce & in_valid & in_ready;
    wire refill = ce & (cnt_r != '0) & (~out_valid | out_ready);
    wire pop_out = ce & out_valid & out_ready;

    // Full counts the array only; output stage is extra room
    assign in_ready = (cnt_r != CW'(DEPTH));
    assign level = cnt_r;

    // Array write
    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem[wr_ptr_r] <= in_data;
    end

    // Pointers and count
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
            if (refill)
                rd_ptr_r <= AW'(rd_ptr_r + 1'b1);
            if (push && !refill)
                cnt_r <= CW'(cnt_r + 1'b1);
            else if (refill && !push)
                cnt_r <= CW'(cnt_r - 1'b1);
        end
    end

    // Output register stage
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            out_valid <= 1'b0;
            out_data <= '0;
        end
        else if (refill)
        begin
            out_valid <= 1'b1;
            out_data <= mem[rd_ptr_r];
        end
        else if (pop_out)
            out_valid <= 1'b0;
    end

endmodule

// ==== bench/dbut_far_drain.sv ====
// Purpose: Far-side drain of the capture log stream
// Assumes: Drain mode is chosen by the bench
// Notes: Mode 0 prompt, 1 slow (one cycle in four), 2 halted

`timescale 1ns/100ps

module dbut_far_drain (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [1:0] mode,
    output logic log_ready
);
    // Phase counter for slow mode
    logic [1:0] phase_r;

    // ********************************************************
    // Ready pattern
    // ********************************************************
    // Registered so ready never changes near the sampling edge
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            phase_r <= 2'h0;
            log_ready <= 1'b0;
        end
        else
        begin
            phase_r <= phase_r + 2'h1;
            log_ready <= (mode == 2'h0) || (mode == 2'h1 && phase_r == 2'h3);
        end
    end
endmodule

// ==== bench/dbut_top_tb.sv ====
// Purpose: Self-checking bench for the dual byte transceiver
// Assumes: Bench drives both pin sides; far drain model takes the log
// Notes: Read data and log words are checked from queues by a watcher

`timescale 1ns/100ps

module dbut_top_tb;
    localparam int CEIL = 5000;     // Cycle ceiling for a hang
    logic clk_sys = 1'b0, srst = 1'b1, ce = 1'b1, xfer_clk = 1'b0, bus_disable = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0, log_valid, log_ready;
    logic [1:0] c2b_open = 2'h0, b2c_open = 2'h0, c2b_en_n = 2'h3, b2c_en_n = 2'h3;
    logic [1:0] mode = 2'h0;        // Drain mode
    logic [15:0] card_in = 16'h0, bp_in = 16'h0, card_out, card_oe, bp_out, bp_oe;
    logic [15:0] log_data, lw, exp_bp = 16'h0, exp_card = 16'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [31:0] exp_oe;            // Expected enables, backplane then card
    logic [15:0] exp_log[$];        // Expected log words
    logic [31:0] exp_rd[$];         // Expected read data
    int bad_count = 0, checks_done = 0, cycles = 0, seed = 97;

    // ********************************************************
    // Clock, design and far side
    // ********************************************************
    initial
    begin
        forever #10 clk_sys = ~clk_sys;
    end

    dbut_top dbut_top_inst (.clk_sys(clk_sys), .srst(srst), .ce(ce), .xfer_clk(xfer_clk),
        .card_to_backplane_latch_open(c2b_open), .backplane_to_card_latch_open(b2c_open),
        .card_to_backplane_drive_en_n(c2b_en_n), .backplane_to_card_drive_en_n(b2c_en_n),
        .bus_disable(bus_disable), .card_in(card_in), .card_out(card_out),
        .card_oe(card_oe), .bp_in(bp_in), .bp_out(bp_out), .bp_oe(bp_oe),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .log_valid(log_valid), .log_ready(log_ready),
        .log_data(log_data));

    dbut_far_drain dbut_far_drain_inst (.clk_sys(clk_sys), .srst(srst), .mode(mode),
        .log_ready(log_ready));

    // ********************************************************
    // Helpers
    // ********************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    function automatic logic [15:0] rnd();
        return 16'($random(seed));
    endfunction

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [31:0] want);
        @(posedge clk_sys);
        exp_rd.push_back(want);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask

    // Capture clock rise; stays high when asked
    task automatic clk_pulse(input logic stay);
        @(posedge clk_sys);
        xfer_clk <= 1'b1;
        if (c2b_open !== 2'b11)
            exp_log.push_back(card_in);
        @(posedge clk_sys);
        if (!stay)
            xfer_clk <= 1'b0;
        exp_bp = card_in;
        exp_card = bp_in;
    endtask

    // ********************************************************
    // Watcher: read data, log words, hang limit
    // ********************************************************
    always @(posedge clk_sys)
    begin
        if (rd_d)
            check(reg_rdata, exp_rd.pop_front());
        rd_d <= reg_rd;
        if (log_valid === 1'b1 && log_ready === 1'b1)
        begin
            lw = (exp_log.size() > 0) ? exp_log.pop_front() : ~log_data;
            check({16'h0, log_data}, {16'h0, lw});
        end
        cycles++;
        if (cycles == CEIL)
        begin
            bad_count++;
            give_verdict();
        end
    end

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial
    begin
        step(6);
        srst <= 1'b0;
        step(2);
        check({bp_oe, card_oe}, 32'h0);
        repeat (3)
        begin
            for (int l = 0; l < 2; l++)
            begin
                @(posedge clk_sys);
                c2b_open <= 2'(2'b01 << l);
                b2c_open <= 2'(2'b10 >> l);
                card_in <= rnd();
                bp_in <= rnd();
                step(2);
                exp_bp[l*8 +: 8] = card_in[l*8 +: 8];
                exp_card[8-l*8 +: 8] = bp_in[8-l*8 +: 8];
                check({bp_out, card_out}, {exp_bp, exp_card});
            end
            @(posedge clk_sys);
            c2b_open <= 2'b00;
            b2c_open <= 2'b00;
            card_in <= rnd();
            bp_in <= rnd();
            step(2);
            check({bp_out, card_out}, {exp_bp, exp_card});
            clk_pulse(1'b1);
            step(1);
            check({bp_out, card_out}, {exp_bp, exp_card});
            @(posedge clk_sys);
            card_in <= rnd();
            bp_in <= rnd();
            step(3);
            check({bp_out, card_out}, {exp_bp, exp_card});
            xfer_clk <= 1'b0;
        end
        // Frozen clock enable: open latch and clock rise leave the paths still
        @(posedge clk_sys);
        ce <= 1'b0;
        c2b_open <= 2'b11;
        card_in <= rnd();
        xfer_clk <= 1'b1;
        step(3);
        check({bp_out, card_out}, {exp_bp, exp_card});
        ce <= 1'b1;
        c2b_open <= 2'b00;
        xfer_clk <= 1'b0;
        // Every enable and disable combination, software disable in the upper half
        for (int k = 0; k < 64; k++)
        begin
            if (k == 32)
                reg_write(dbut_pkg::ADDR_CTRL, 32'h0000_0001);
            @(posedge clk_sys);
            {bus_disable, c2b_en_n, b2c_en_n} <= k[4:0];
            step(2);
            exp_oe = {32{!(k[4] || k[5])}} & ~{{8{k[3]}}, {8{k[2]}}, {8{k[1]}}, {8{k[0]}}};
            check({bp_oe, card_oe}, exp_oe);
        end
        reg_read(dbut_pkg::ADDR_CTRL, 32'h0000_0001);
        reg_write(dbut_pkg::ADDR_CTRL, 32'h0000_0000);
        reg_write(8'h0c, 32'hffff_ffff);
        reg_read(8'h0c, 32'h0000_0000);
        reg_read(dbut_pkg::ADDR_CTRL, 32'h0000_0000);
        // Fill the log with the drain halted, then drain slowly
        mode <= 2'h2;
        step(4);
        repeat (40)
        begin
            @(posedge clk_sys);
            card_in <= rnd();
            clk_pulse(1'b0);
        end
        step(4);
        while (exp_log.size() > 33)
            void'(exp_log.pop_back());
        reg_read(dbut_pkg::ADDR_LOG, 32'd32);
        reg_read(dbut_pkg::ADDR_CTRL, 32'h0000_0100);
        reg_read(dbut_pkg::ADDR_HELD, {exp_card, exp_bp});
        mode <= 2'h1;
        for (int w = 0; w < 400 && exp_log.size() > 0; w++)
            @(posedge clk_sys);
        step(8);
        check({31'h0, log_valid}, 32'h0);
        check(32'(exp_log.size()), 32'h0);
        reg_write(dbut_pkg::ADDR_CTRL, 32'h0000_0002);
        reg_read(dbut_pkg::ADDR_CTRL, 32'h0000_0000);
        reg_read(dbut_pkg::ADDR_LOG, 32'h0000_0000);
        step(3);
        give_verdict();
    end
endmodule
